// >>> hdl/rooc_pkg.sv
// Constants and carrier types of the resizer output order control bank.
// Assumes a plain register port with 8-bit byte addresses and 32-bit data.
package rooc_pkg;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PIX_W = 16;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CHROMA_PHASE = 8'h00;
	localparam logic [7:0] OFF_ORDER = 8'h04;
	localparam logic [7:0] OFF_CH_A_ENABLE = 8'h08;
	localparam logic [7:0] OFF_CH_A_RUN_SEL = 8'h0C;
	localparam logic [7:0] OFF_CLOCK_GATE = 8'h10;
	localparam logic [7:0] OFF_SOURCE_FORMAT = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_PHASE_MID = 0;
	localparam int BIT_FLIP_H_A = 0;
	localparam int BIT_FLIP_V_A = 1;
	localparam int BIT_FLIP_H_B = 2;
	localparam int BIT_FLIP_V_B = 3;
	localparam int BIT_SAMPLE_SHIFT = 4;
	localparam int BIT_ENABLE = 0;
	localparam int BIT_SINGLE = 0;
	localparam int BIT_GATE = 0;
	localparam int BIT_PASSTHROUGH = 0;
	localparam int BIT_ST_RUN = 2;
	localparam int BIT_ST_DONE = 3;
	localparam int ORDER_W = 5;

	// ----------------------------------------------------------------
	// Reset values and run modes
	// ----------------------------------------------------------------
	localparam logic RST_BIT = 1'b0;
	localparam logic [ORDER_W-1:0] RST_ORDER = 5'h00;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;
	localparam logic [1:0] MODE_RESCALE = 2'h0;
	localparam logic [1:0] MODE_BYPASS = 2'h1;
	localparam logic [1:0] MODE_PASSTHROUGH = 2'h2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [PIX_W-1:0] data;
		logic sol;
		logic eol;
	} rooc_pix_t;

	typedef struct packed {
		logic chroma_mid;
		logic chroma_sample_shift;
		logic second_channel_vertical_flip;
		logic second_channel_horizontal_flip;
		logic first_channel_vertical_flip;
		logic first_channel_horizontal_flip;
	} rooc_order_t;

endpackage : rooc_pkg

// >>> hdl/rooc_top.sv
// Control bank and first-channel line stage of the resizer output path.
// Assumes pixels and the vertical sync come from logic on sys_clk, and that
// the output path to memory applies the flip and chroma phase controls.
//
// Contract
// - Chroma phase bit selects co-sited or midway chroma
// - Shift bit moves chroma sampling to even pixels
// - Shift drops leftmost pixel, repeats rightmost pixel (one-pixel lines pass whole, no drop or copy)
// - Bit 3 flips second channel vertically
// - Bit 2 flips second channel horizontally
// - Bit 1 flips first channel vertically
// - Bit 0 flips first channel horizontally
// - First channel runs only while enabled
// - One-shot mode clears enable on vertical sync
// - Pass-through output gated by enable bit
// - Select bit: 0 continuous, 1 one-shot
// - Gate 0 with bypass 1 means pass-through
`timescale 1ns/1ps
module rooc_top (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [rooc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rooc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [rooc_pkg::DATA_W-1:0] reg_rdata,
	input wire logic vertical_sync_pulse,
	input wire logic pix_in_valid,
	input wire rooc_pkg::rooc_pix_t pix_in,
	output logic pix_out_valid,
	output rooc_pkg::rooc_pix_t pix_out,
	output rooc_pkg::rooc_order_t order_out,
	output logic [1:0] run_mode,
	output logic first_channel_run
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [rooc_pkg::ADDR_W-1:0] addr,
			input logic [rooc_pkg::ADDR_W-1:0] off);
		addr_hit = (addr == off);
	endfunction : addr_hit

	function automatic logic [1:0] mode_of(input logic gate, input logic passthrough);
		logic [1:0] m;
		m = rooc_pkg::MODE_RESCALE;
		if (!gate) begin
			m = passthrough ? rooc_pkg::MODE_PASSTHROUGH : rooc_pkg::MODE_BYPASS;
		end
		mode_of = m;
	endfunction : mode_of

	typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_DONE} rooc_state_t;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic phase_reg;
	logic [rooc_pkg::ORDER_W-1:0] order_reg;
	logic enable_reg;
	logic enable_next;
	logic single_reg;
	logic gate_reg;
	logic passthrough_reg;
	logic [1:0] mode_reg;
	rooc_state_t state_reg;
	rooc_state_t state_next;
	logic [rooc_pkg::DATA_W-1:0] rdata_reg;
	logic [rooc_pkg::DATA_W-1:0] rdata_next;

	wire wr_phase = reg_wr && addr_hit(reg_addr, rooc_pkg::OFF_CHROMA_PHASE);
	wire wr_order = reg_wr && addr_hit(reg_addr, rooc_pkg::OFF_ORDER);
	wire wr_enable = reg_wr && addr_hit(reg_addr, rooc_pkg::OFF_CH_A_ENABLE);
	wire wr_single = reg_wr && addr_hit(reg_addr, rooc_pkg::OFF_CH_A_RUN_SEL);
	wire wr_gate = reg_wr && addr_hit(reg_addr, rooc_pkg::OFF_CLOCK_GATE);
	wire wr_format = reg_wr && addr_hit(reg_addr, rooc_pkg::OFF_SOURCE_FORMAT);

	wire single_end = vertical_sync_pulse && single_reg && enable_reg;

	// software write beats the vsync clear
	assign enable_next = wr_enable ? reg_wdata[rooc_pkg::BIT_ENABLE] :
		(single_end ? 1'b0 : enable_reg);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CH_IDLE: begin
				if (enable_next) begin
					state_next = CH_RUN;
				end
			end
			CH_RUN: begin
				if (!enable_next) begin
					state_next = single_end ? CH_DONE : CH_IDLE;
				end
			end
			CH_DONE: begin
				if (enable_next) begin
					state_next = CH_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase_reg <= rooc_pkg::RST_BIT;
			order_reg <= rooc_pkg::RST_ORDER;
			single_reg <= rooc_pkg::RST_BIT;
			gate_reg <= rooc_pkg::RST_BIT;
			passthrough_reg <= rooc_pkg::RST_BIT;
		end else begin
			if (wr_phase) begin
				phase_reg <= reg_wdata[rooc_pkg::BIT_PHASE_MID];
			end
			if (wr_order) begin
				order_reg <= reg_wdata[rooc_pkg::ORDER_W-1:0];
			end
			if (wr_single) begin
				single_reg <= reg_wdata[rooc_pkg::BIT_SINGLE];
			end
			if (wr_gate) begin
				gate_reg <= reg_wdata[rooc_pkg::BIT_GATE];
			end
			if (wr_format) begin
				passthrough_reg <= reg_wdata[rooc_pkg::BIT_PASSTHROUGH];
			end
		end
	end

	// run mode from gate and bypass
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			enable_reg <= rooc_pkg::RST_BIT;
			state_reg <= CH_IDLE;
			mode_reg <= rooc_pkg::MODE_RESCALE;
		end else begin
			enable_reg <= enable_next;
			state_reg <= state_next;
			mode_reg <= mode_of(gate_reg, passthrough_reg);
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire [rooc_pkg::DATA_W-1:0] status_word = {28'h0000000, state_reg == CH_DONE,
		state_reg == CH_RUN, mode_reg};
	wire [rooc_pkg::DATA_W-1:0] read_word =
		addr_hit(reg_addr, rooc_pkg::OFF_CHROMA_PHASE) ? {31'h00000000, phase_reg} :
		addr_hit(reg_addr, rooc_pkg::OFF_ORDER) ? {27'h0000000, order_reg} :
		addr_hit(reg_addr, rooc_pkg::OFF_CH_A_ENABLE) ? {31'h00000000, enable_reg} :
		addr_hit(reg_addr, rooc_pkg::OFF_CH_A_RUN_SEL) ? {31'h00000000, single_reg} :
		addr_hit(reg_addr, rooc_pkg::OFF_CLOCK_GATE) ? {31'h00000000, gate_reg} :
		addr_hit(reg_addr, rooc_pkg::OFF_SOURCE_FORMAT) ? {31'h00000000, passthrough_reg} :
		addr_hit(reg_addr, rooc_pkg::OFF_STATUS) ? status_word :
		rooc_pkg::RDATA_IDLE;

	// Data only in the cycle after the strobe, zero otherwise
	assign rdata_next = reg_rd ? read_word : rooc_pkg::RDATA_IDLE;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_reg <= rooc_pkg::RDATA_IDLE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// First-channel line stage
	// ----------------------------------------------------------------
	logic out_valid_reg;
	rooc_pkg::rooc_pix_t out_reg;
	logic pend_sol_reg;
	logic dup_reg;

	wire shift = order_reg[rooc_pkg::BIT_SAMPLE_SHIFT];

	wire in_ok = pix_in_valid && enable_reg;

	// leftmost pixel swallowed; one-pixel lines pass whole
	wire drop = shift && pix_in.sol && !pix_in.eol;
	wire in_pass = in_ok && !drop;

	// last pixel emitted twice, eol on the copy
	wire out_valid_next = in_pass || dup_reg;
	// One-pixel lines keep their length, so they get no copy
	wire line_long = !(pix_in.sol && pix_in.eol);
	wire dup_next = in_pass && shift && pix_in.eol && line_long;
	wire pend_sol_next = in_pass ? 1'b0 : ((in_ok && drop) ? 1'b1 : pend_sol_reg);
	wire rooc_pkg::rooc_pix_t out_next = in_pass ?
		rooc_pkg::rooc_pix_t'{data: pix_in.data, sol: pix_in.sol || pend_sol_reg,
			eol: pix_in.eol && !(shift && line_long)} :
		(dup_reg ? rooc_pkg::rooc_pix_t'{data: out_reg.data, sol: 1'b0, eol: 1'b1} : out_reg);

	// Copy slot is free only because the next line's first pixel is dropped
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			out_valid_reg <= 1'b0;
			out_reg <= '0;
			pend_sol_reg <= 1'b0;
			dup_reg <= 1'b0;
		end else begin
			out_valid_reg <= out_valid_next;
			out_reg <= out_next;
			pend_sol_reg <= pend_sol_next;
			dup_reg <= dup_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_reg;
	assign pix_out_valid = out_valid_reg;
	assign pix_out = out_reg;
	assign run_mode = mode_reg;
	assign first_channel_run = enable_reg;

	assign order_out = rooc_pkg::rooc_order_t'{
		chroma_mid: phase_reg,
		chroma_sample_shift: shift,
		second_channel_vertical_flip: order_reg[rooc_pkg::BIT_FLIP_V_B],
		second_channel_horizontal_flip: order_reg[rooc_pkg::BIT_FLIP_H_B],
		first_channel_vertical_flip: order_reg[rooc_pkg::BIT_FLIP_V_A],
		first_channel_horizontal_flip: order_reg[rooc_pkg::BIT_FLIP_H_A]
	};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	sequence s_last_pixel;
		in_pass && shift && pix_in.eol && !pix_in.sol;
	endsequence

	sequence s_single_end;
		single_end && !wr_enable;
	endsequence

	a_phase_write: assert property (
		wr_phase |=> order_out.chroma_mid == $past(reg_wdata[0]) ##1
			($past(wr_phase) || $stable(order_out.chroma_mid)))
	else $error("chroma phase not taken from write");

	a_shift_drop: assert property (
		(in_ok && drop && !dup_reg) |=> !pix_out_valid)
	else $error("leftmost pixel not dropped under shift");

	a_shift_first_sol: assert property (
		(in_ok && drop) ##1 (in_pass && !drop) |=> pix_out_valid && pix_out.sol)
	else $error("second pixel not marked line start");

	a_shift_repeat: assert property (
		s_last_pixel |=> (pix_out_valid && !pix_out.eol) ##1
			($past(in_pass) || (pix_out_valid && pix_out.eol && $stable(pix_out.data))))
	else $error("rightmost pixel not repeated");

	a_flip_b: assert property (
		wr_order |=> {order_out.second_channel_vertical_flip,
			order_out.second_channel_horizontal_flip} == $past(reg_wdata[3:2]))
	else $error("second channel flip bits wrong");

	a_flip_a: assert property (
		wr_order |=> {order_out.first_channel_vertical_flip,
			order_out.first_channel_horizontal_flip} == $past(reg_wdata[1:0]))
	else $error("first channel flip bits wrong");

	a_off_quiet: assert property (
		(!enable_reg && !dup_reg) |=> !pix_out_valid)
	else $error("output while channel disabled");

	a_single_clear: assert property (
		s_single_end |=> !enable_reg && !first_channel_run)
	else $error("one-shot enable not cleared on vsync");

	a_cont_hold: assert property (
		(!single_reg && enable_reg && vertical_sync_pulse && !wr_enable) |=> enable_reg)
	else $error("continuous mode lost enable on vsync");

	a_pass_mode: assert property (
		(!gate_reg && passthrough_reg) |=> run_mode == rooc_pkg::MODE_PASSTHROUGH)
	else $error("pass-through mode not reported");

	a_single_park: assert property (
		s_single_end ##1 !wr_enable [*3] |-> state_reg == CH_DONE && !enable_reg)
	else $error("one-shot channel did not stay idle");

endmodule : rooc_top

// >>> verif/rooc_pipe_model.sv
// Behavioural model of the image pipe that feeds pixels and the vertical sync.
// Assumes the caller invokes its tasks from the bench on sys_clk.
`timescale 1ns/1ps
module rooc_pipe_model (
	input wire logic sys_clk,
	output logic vertical_sync_pulse,
	output logic pix_in_valid,
	output rooc_pkg::rooc_pix_t pix_in
);

	initial begin
		vertical_sync_pulse = 1'b0;
		pix_in_valid = 1'b0;
		pix_in = '0;
	end

	// ----------------------------------------------------------------
	// Stream tasks
	// ----------------------------------------------------------------
	// Idle data toggles so stale pixels never look valid by accident
	task idle_cycle;
		@(posedge sys_clk);
		pix_in_valid <= 1'b0;
		pix_in <= ~pix_in;
	endtask : idle_cycle

	// Gap 0 streams at full rate; the cycle after the last pixel stays idle
	task send_line(input int n, input logic [15:0] base, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			pix_in_valid <= 1'b1;
			pix_in.data <= base + 16'(i);
			pix_in.sol <= (i == 0);
			pix_in.eol <= (i == n - 1);
			repeat (gap) idle_cycle();
		end
		idle_cycle();
	endtask : send_line

	task vsync;
		@(posedge sys_clk);
		vertical_sync_pulse <= 1'b1;
		@(posedge sys_clk);
		vertical_sync_pulse <= 1'b0;
	endtask : vsync

endmodule : rooc_pipe_model

// >>> verif/tb.sv
// Self-checking bench of the resizer output order control bank.
// Assumes the pipe model drives the stream and the bench owns the register port.
`timescale 1ns/1ps
module tb;

	logic sys_clk, srst, reg_wr, reg_rd, vertical_sync_pulse, pix_in_valid;
	logic pix_out_valid, first_channel_run;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_val;
	logic [1:0] run_mode;
	rooc_pkg::rooc_pix_t pix_in, pix_out;
	rooc_pkg::rooc_order_t order_out;
	rooc_pkg::rooc_pix_t got_q[$], exp_q[$];
	int err_total, check_count;

	rooc_top u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.vertical_sync_pulse(vertical_sync_pulse), .pix_in_valid(pix_in_valid), .pix_in(pix_in),
		.pix_out_valid(pix_out_valid), .pix_out(pix_out), .order_out(order_out),
		.run_mode(run_mode), .first_channel_run(first_channel_run));
	rooc_pipe_model u_pipe (.sys_clk(sys_clk), .vertical_sync_pulse(vertical_sync_pulse),
		.pix_in_valid(pix_in_valid), .pix_in(pix_in));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) if (pix_out_valid === 1'b1) got_q.push_back(pix_out);

	// ----------------------------------------------------------------
	// Checks and bus tasks
	// ----------------------------------------------------------------
	task end_sim;
		if (err_total == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim

	task chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk32

	task chk_pix(input rooc_pkg::rooc_pix_t got, input rooc_pkg::rooc_pix_t exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: pixel got %h expected %h", $time, got, exp);
		end
	endtask : chk_pix

	task reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk32(reg_rdata, exp, what);
	endtask : rd_chk

	task wr_rd(input logic [7:0] a, input logic [31:0] d);
		reg_write(a, d);
		rd_chk(a, d, "readback");
	endtask : wr_rd

	function automatic rooc_pkg::rooc_pix_t mk(input logic [15:0] d, input logic s, input logic e);
		mk = rooc_pkg::rooc_pix_t'{data: d, sol: s, eol: e};
	endfunction : mk

	// Shifted lines of two or more pixels lose the first pixel and repeat the last one
	task line(input int n, input logic [15:0] base, input int gap, input bit sh, input bit en);
		for (int i = 0; i < n; i++) begin
			if (en && (!sh || n == 1)) exp_q.push_back(mk(base + 16'(i), i == 0, i == n - 1));
			else if (en && i > 0) exp_q.push_back(mk(base + 16'(i), i == 1, 1'b0));
		end
		if (en && sh && n > 1) exp_q.push_back(mk(base + 16'(n - 1), 1'b0, 1'b1));
		u_pipe.send_line(n, base, gap);
		repeat (4) @(posedge sys_clk);
		chk32(32'(got_q.size()), 32'(exp_q.size()), "pixel count");
		for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) chk_pix(got_q[i], exp_q[i]);
		got_q.delete();
		exp_q.delete();
	endtask : line

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		err_total = 0;
		check_count = 0;
		srst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		for (int a = 0; a < 6; a++) rd_chk(8'(a * 4), 32'h0, "reset value");
		reg_write(8'h1C, 32'h1);
		rd_chk(8'h1C, 32'h0, "unmapped");
		wr_rd(rooc_pkg::OFF_CHROMA_PHASE, 32'h1);
		chk32({26'h0, order_out}, 32'h20, "chroma mid");
		for (int i = 0; i < 5; i++) begin
			wr_rd(rooc_pkg::OFF_ORDER, 32'h1 << i);
			chk32({26'h0, order_out}, 32'h20 | (32'h1 << i), "order bit");
		end
		wr_rd(rooc_pkg::OFF_CHROMA_PHASE, 32'h0);
		wr_rd(rooc_pkg::OFF_ORDER, 32'h0);
		for (int i = 0; i < 4; i++) begin
			reg_write(rooc_pkg::OFF_CLOCK_GATE, {31'h0, ~i[0]});
			reg_write(rooc_pkg::OFF_SOURCE_FORMAT, {31'h0, i[1]});
			@(posedge sys_clk);
			#1;
			rd_val = i[0] ? (i[1] ? 32'h2 : 32'h1) : 32'h0;
			chk32({30'h0, run_mode}, rd_val, "run mode");
			rd_chk(rooc_pkg::OFF_STATUS, rd_val, "status mode");
		end
		line(3, 16'h0100, 0, 0, 0);
		wr_rd(rooc_pkg::OFF_CH_A_ENABLE, 32'h1);
		chk32({31'h0, first_channel_run}, 32'h1, "run flag");
		rd_chk(rooc_pkg::OFF_STATUS, 32'h6, "running status");
		line(3, 16'h0200, 0, 0, 1);
		line(2, 16'h0300, 2, 0, 1);
		wr_rd(rooc_pkg::OFF_ORDER, 32'h10);
		line(4, 16'h0400, 0, 1, 1);
		line(4, 16'h0500, 1, 1, 1);
		line(1, 16'h0600, 0, 1, 1);
		wr_rd(rooc_pkg::OFF_ORDER, 32'h0);
		u_pipe.vsync();
		@(posedge sys_clk);
		#1;
		chk32({31'h0, first_channel_run}, 32'h1, "continuous keeps");
		wr_rd(rooc_pkg::OFF_CH_A_RUN_SEL, 32'h1);
		u_pipe.vsync();
		@(posedge sys_clk);
		#1;
		chk32({31'h0, first_channel_run}, 32'h0, "one-shot clear");
		rd_chk(rooc_pkg::OFF_CH_A_ENABLE, 32'h0, "enable cleared");
		rd_chk(rooc_pkg::OFF_STATUS, 32'hA, "done status");
		line(3, 16'h0700, 0, 0, 0);
		wr_rd(rooc_pkg::OFF_CH_A_ENABLE, 32'h1);
		rd_chk(rooc_pkg::OFF_STATUS, 32'h6, "rerun status");
		line(2, 16'h0800, 0, 0, 1);
		end_sim();
	end

	initial begin
		repeat (6000) @(posedge sys_clk);
		err_total++;
		$display("wrong value at %0t: run hung", $time);
		end_sim();
	end

endmodule : tb
